// [rtl/dsas_access.v]
// data-space access path, working-register byte loads and stack pointer
`include "dsas_map.vh"
module dsas_access (
   input wire clk_in, // core clock
   input wire reset_n_in, // async reset, active low
   input wire enable_in, // clock enable
   input wire rd_req_in, // read request
   input wire rd_byte_in, // read is byte wide
   input wire [1:0] rd_mode_in, // 0 indirect, 1 direct16, 2 near13
   input wire [15:0] rd_operand_in, // direct address or field
   input wire [3:0] rd_reg_in, // pointer register
   input wire rd_postinc_in, // post-increment pointer
   input wire [3:0] rd_dest_in, // destination working register
   input wire [1:0] rd_ext_in, // load/extend select
   input wire wr_req_in, // write request
   input wire wr_byte_in, // write is byte wide
   input wire [1:0] wr_mode_in, // 0 indirect, 1 direct16, 2 near13
   input wire [15:0] wr_operand_in, // direct address or field
   input wire [3:0] wr_reg_in, // pointer register
   input wire wr_postinc_in, // post-increment pointer
   input wire [15:0] wr_data_in, // write data
   input wire [7:0] read_page_reg_in, // read page
   input wire [7:0] write_page_reg_in, // write page
   input wire frame_active_flag_in, // register 14 is frame pointer
   input wire reg_wr_in, // plain register write
   input wire [3:0] reg_wr_sel_in, // register to write
   input wire [15:0] reg_wr_data_in, // value to write
   input wire [2:0] stack_op_in, // stack command
   input wire [22:0] pc_in, // program counter
   input wire [7:0] status_low_byte_in, // cpu status low byte
   input wire [15:0] push_data_in, // data word for plain push
   input wire [3:0] reg_rd_sel_in, // register to observe
   output reg [15:0] reg_rd_data_out, // observed register
   output reg [15:0] stack_pointer_reg_out, // stack pointer
   output reg [15:0] rd_data_out, // read result
   output reg rd_valid_out, // read result valid
   output reg [23:0] rd_ext_addr_out, // extended read address
   output reg [23:0] wr_ext_addr_out, // extended write address
   output reg addr_error_trap_out, // misaligned access trap pulse
   output reg [22:0] pop_pc_out, // popped program counter
   output reg [7:0] pop_status_out, // popped status low byte
   output reg pop_valid_out // pop result valid
);
   localparam ST_IDLE = 3'h0;
   localparam ST_PUSH_HI = 3'h1;
   localparam ST_POP_LO = 3'h2;
   localparam ST_POP_WAIT = 3'h3;
   localparam ST_POP_DONE = 3'h4;
   localparam SP_IDX = 4'hf;
   localparam FP_IDX = 4'he;

   reg [15:0] wreg [0:15];
   reg [2:0] state;
   reg [2:0] next_state;
   reg [7:0] push_hi;
   reg [6:0] push_pc_hi;
   reg ret_full;
   reg [15:0] pop_hi;
   reg rd_pend;
   reg rd_pend_byte;
   reg rd_pend_odd;
   reg rd_pend_zero;
   reg [1:0] rd_pend_ext;
   reg [3:0] rd_pend_dest;
   reg trap_pend;
   reg [15:0] rd_ea;
   reg [15:0] wr_ea;
   reg [15:0] mem_rd_ea;
   reg [15:0] mem_wr_ea;
   reg [1:0] mem_lane;
   reg [15:0] mem_wdata;
   reg stack_rd;
   wire [15:0] mem_rdata;
   wire rd_misalign;
   wire wr_misalign;
   wire [15:0] sp;
   integer i;

   // address generation shared by both units
   function [15:0] agu_ea;
      input [1:0] mode;
      input [15:0] operand;
      input [15:0] ptr;
      begin
         case (mode)
            2'h1: agu_ea = operand;
            2'h2: agu_ea = operand & `DSAS_NEAR_MASK;
            default: agu_ea = ptr;
         endcase
      end
   endfunction

   // post-modify step
   function [15:0] agu_step;
      input is_byte;
      begin
         agu_step = is_byte ? `DSAS_STEP_BYTE : `DSAS_STEP_WORD;
      end
   endfunction

   // page extension, indirect via stack pointer or active frame pointer never paged
   function [23:0] agu_extend;
      input [7:0] page;
      input [3:0] ptr;
      input [1:0] mode;
      input frame_on;
      begin
         if (mode == 2'h0 && (ptr == SP_IDX || (ptr == FP_IDX && frame_on))) begin
            agu_extend = {`DSAS_ZERO_PAGE, 16'h0000};
         end else begin
            agu_extend = {page, 16'h0000};
         end
      end
   endfunction

   assign sp = wreg[SP_IDX];

   // separate read and write units
   always @* begin
      rd_ea = agu_ea(rd_mode_in, rd_operand_in, wreg[rd_reg_in]);
      wr_ea = agu_ea(wr_mode_in, wr_operand_in, wreg[wr_reg_in]);
   end

   assign rd_misalign = rd_req_in && !rd_byte_in && rd_ea[0];
   assign wr_misalign = wr_req_in && !wr_byte_in && wr_ea[0];

   // memory port steering: stack sequencer or data access
   always @* begin
      mem_rd_ea = rd_ea;
      mem_wr_ea = wr_ea;
      mem_lane = 2'h0;
      mem_wdata = wr_data_in;
      stack_rd = 1'b0;
      next_state = state;
      case (state)
         ST_IDLE: begin
            case (stack_op_in)
               `DSAS_OP_CALL, `DSAS_OP_TRAP: begin
                  mem_wr_ea = sp;
                  mem_wdata = pc_in[15:0];
                  mem_lane = 2'h3;
                  next_state = ST_PUSH_HI;
               end
               `DSAS_OP_PUSH: begin
                  mem_wr_ea = sp;
                  mem_wdata = push_data_in;
                  mem_lane = 2'h3;
               end
               `DSAS_OP_RET, `DSAS_OP_RETFIE, `DSAS_OP_POP: begin
                  mem_rd_ea = sp - `DSAS_STEP_WORD;
                  stack_rd = 1'b1;
                  next_state = (stack_op_in == `DSAS_OP_POP) ? ST_POP_DONE : ST_POP_LO;
               end
               default: begin
                  if (wr_req_in && !wr_misalign) begin
                     mem_lane = wr_byte_in ? (wr_ea[0] ? 2'h2 : 2'h1) : 2'h3;
                     mem_wdata = wr_byte_in ? {wr_data_in[7:0], wr_data_in[7:0]} : wr_data_in;
                  end
               end
            endcase
         end
         ST_PUSH_HI: begin
            mem_wr_ea = sp;
            mem_wdata = {push_hi, 1'b0, push_pc_hi};
            mem_lane = 2'h3;
            next_state = ST_IDLE;
         end
         ST_POP_LO: begin
            mem_rd_ea = sp - `DSAS_STEP_WORD;
            stack_rd = 1'b1;
            next_state = ST_POP_WAIT;
         end
         ST_POP_WAIT: begin
            mem_rd_ea = sp; // hold the low word on the read port
            next_state = ST_POP_DONE;
         end
         ST_POP_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
      if (mem_wr_ea > `DSAS_IMPL_LAST) begin
         mem_lane = 2'h0; // nothing implemented there
      end
   end

   dsas_memory u_mem (
      .clk_in(clk_in),
      .enable_in(enable_in),
      .read_word_in(mem_rd_ea[15:1]),
      .read_data_out(mem_rdata),
      .write_word_in(mem_wr_ea[15:1]),
      .write_lane_in(mem_lane),
      .write_data_in(mem_wdata)
   );

   // registers, stack pointer, read return and traps
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (i = 0; i < 16; i = i + 1) begin
            wreg[i] <= `DSAS_ZERO_WORD;
         end
         wreg[SP_IDX] <= `DSAS_SP_RESET;
         state <= ST_IDLE;
         push_hi <= `DSAS_ZERO_BYTE;
         push_pc_hi <= 7'h00;
         ret_full <= 1'b0;
         pop_hi <= `DSAS_ZERO_WORD;
         rd_pend <= 1'b0;
         rd_pend_byte <= 1'b0;
         rd_pend_odd <= 1'b0;
         rd_pend_zero <= 1'b0;
         rd_pend_ext <= `DSAS_EXT_NONE;
         rd_pend_dest <= 4'h0;
         trap_pend <= 1'b0;
         reg_rd_data_out <= `DSAS_ZERO_WORD;
         stack_pointer_reg_out <= `DSAS_SP_RESET;
         rd_data_out <= `DSAS_ZERO_WORD;
         rd_valid_out <= 1'b0;
         rd_ext_addr_out <= 24'h000000;
         wr_ext_addr_out <= 24'h000000;
         addr_error_trap_out <= 1'b0;
         pop_pc_out <= 23'h000000;
         pop_status_out <= `DSAS_ZERO_BYTE;
         pop_valid_out <= 1'b0;
      end else if (enable_in) begin
         state <= next_state;
         rd_valid_out <= 1'b0;
         pop_valid_out <= 1'b0;
         addr_error_trap_out <= trap_pend;
         trap_pend <= rd_misalign || wr_misalign;
         if (reg_wr_in) begin
            wreg[reg_wr_sel_in] <= reg_wr_data_in;
            if (reg_wr_sel_in == SP_IDX) begin
               wreg[SP_IDX] <= {reg_wr_data_in[15:1], 1'b0};
            end
         end
         // pointer post-modify
         if (rd_req_in && rd_postinc_in && rd_mode_in == 2'h0) begin
            wreg[rd_reg_in] <= rd_ea + agu_step(rd_byte_in);
         end
         if (wr_req_in && wr_postinc_in && wr_mode_in == 2'h0) begin
            wreg[wr_reg_in] <= wr_ea + agu_step(wr_byte_in);
         end
         // extended addresses stand from one request to the next
         if (rd_req_in) begin
            rd_ext_addr_out <= agu_extend(read_page_reg_in, rd_reg_in, rd_mode_in, frame_active_flag_in) | {8'h00, rd_ea};
         end
         if (wr_req_in) begin
            wr_ext_addr_out <= agu_extend(write_page_reg_in, wr_reg_in, wr_mode_in, frame_active_flag_in) | {8'h00, wr_ea};
         end
         // data read tracked one cycle for memory latency
         rd_pend <= rd_req_in && state == ST_IDLE && !stack_rd;
         rd_pend_byte <= rd_byte_in;
         rd_pend_odd <= rd_ea[0];
         rd_pend_zero <= rd_ea > `DSAS_IMPL_LAST;
         rd_pend_ext <= rd_ext_in;
         rd_pend_dest <= rd_dest_in;
         if (rd_pend) begin
            rd_valid_out <= 1'b1;
            if (rd_pend_zero) begin
               rd_data_out <= `DSAS_ZERO_WORD;
            end else if (rd_pend_byte) begin
               rd_data_out <= {8'h00, rd_pend_odd ? mem_rdata[15:8] : mem_rdata[7:0]};
            end else begin
               rd_data_out <= mem_rdata;
            end
            if (rd_pend_byte && rd_pend_ext == `DSAS_EXT_BYTE) begin
               wreg[rd_pend_dest][7:0] <= rd_pend_zero ? `DSAS_ZERO_BYTE
                  : (rd_pend_odd ? mem_rdata[15:8] : mem_rdata[7:0]);
            end
         end
         // register-only extend operations
         if (rd_ext_in == `DSAS_EXT_SIGN && !rd_req_in) begin
            wreg[rd_dest_in] <= {{8{wreg[rd_dest_in][7]}}, wreg[rd_dest_in][7:0]};
         end
         if (rd_ext_in == `DSAS_EXT_ZERO && !rd_req_in) begin
            wreg[rd_dest_in] <= {8'h00, wreg[rd_dest_in][7:0]};
         end
         // stack sequencer pointer updates
         case (state)
            ST_IDLE: begin
               push_hi <= (stack_op_in == `DSAS_OP_TRAP) ? status_low_byte_in : `DSAS_ZERO_BYTE;
               ret_full <= stack_op_in == `DSAS_OP_RETFIE;
               push_pc_hi <= pc_in[22:16];
               if (stack_op_in == `DSAS_OP_POP) begin
                  pop_hi <= `DSAS_ZERO_WORD; // plain pop carries no upper bits
               end
               if (stack_op_in == `DSAS_OP_CALL || stack_op_in == `DSAS_OP_TRAP || stack_op_in == `DSAS_OP_PUSH) begin
                  wreg[SP_IDX] <= sp + `DSAS_STEP_WORD;
               end
               if (stack_op_in == `DSAS_OP_RET || stack_op_in == `DSAS_OP_RETFIE || stack_op_in == `DSAS_OP_POP) begin
                  wreg[SP_IDX] <= sp - `DSAS_STEP_WORD;
               end
            end
            ST_PUSH_HI: wreg[SP_IDX] <= sp + `DSAS_STEP_WORD;
            ST_POP_LO: begin
               pop_hi <= mem_rdata;
               wreg[SP_IDX] <= sp - `DSAS_STEP_WORD;
            end
            ST_POP_DONE: begin
               pop_valid_out <= 1'b1;
               pop_pc_out <= {pop_hi[6:0], mem_rdata};
               pop_status_out <= ret_full ? pop_hi[15:8] : `DSAS_ZERO_BYTE;
            end
            default: ;
         endcase
         stack_pointer_reg_out <= sp;
         reg_rd_data_out <= wreg[reg_rd_sel_in];
      end
   end
endmodule // dsas_access

// [rtl/dsas_memory.v]
// byte-lane data memory covering special registers and ram
`include "dsas_map.vh"
module dsas_memory (
   input wire clk_in, // core clock
   input wire enable_in, // clock enable
   input wire [14:0] read_word_in, // read word index
   output reg [15:0] read_data_out, // read word
   input wire [14:0] write_word_in, // write word index
   input wire [1:0] write_lane_in, // byte write strobes
   input wire [15:0] write_data_in // write word
);
   localparam WORDS = `DSAS_SFR_WORDS + `DSAS_RAM_WORDS;
   reg [7:0] lane_lo [0:WORDS-1];
   reg [7:0] lane_hi [0:WORDS-1];

   // shared word decode, separate lane strobes
   always @(posedge clk_in) begin
      if (enable_in) begin
         if (write_lane_in[0]) begin
            lane_lo[write_word_in] <= write_data_in[7:0];
         end
         if (write_lane_in[1]) begin
            lane_hi[write_word_in] <= write_data_in[15:8];
         end
         read_data_out <= {lane_hi[read_word_in], lane_lo[read_word_in]};
      end
   end
endmodule // dsas_memory

// [shared/dsas_map.vh]
// address map, field positions, reset values and command codes of the data-space access block
`ifndef DSAS_MAP_VH
`define DSAS_MAP_VH
`define DSAS_SFR_LAST 16'h0fff
`define DSAS_NEAR_LAST 16'h1fff
`define DSAS_IMPL_LAST 16'hcfff
`define DSAS_SP_RESET 16'h1000
`define DSAS_ZERO_WORD 16'h0000
`define DSAS_ZERO_BYTE 8'h00
`define DSAS_ZERO_PAGE 8'h00
`define DSAS_STEP_BYTE 16'h0001
`define DSAS_STEP_WORD 16'h0002
`define DSAS_NEAR_MASK 16'h1fff
`define DSAS_RAM_WORDS 24576
`define DSAS_SFR_WORDS 2048
`define DSAS_RAM_BASE 16'h1000
`define DSAS_OP_NONE 3'h0
`define DSAS_OP_CALL 3'h1
`define DSAS_OP_TRAP 3'h2
`define DSAS_OP_RET 3'h3
`define DSAS_OP_RETFIE 3'h4
`define DSAS_OP_PUSH 3'h5
`define DSAS_OP_POP 3'h6
`define DSAS_EXT_NONE 2'h0
`define DSAS_EXT_SIGN 2'h1
`define DSAS_EXT_ZERO 2'h2
`define DSAS_EXT_BYTE 2'h3
`endif

// [verification/data_space_access_and_stack_test.sv]
// self-checking testbench for the data-space access block
module data_space_access_and_stack_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, reset_n_in, enable_in, frame_active_flag_in, reg_wr_in;
   logic [7:0] read_page_reg_in, write_page_reg_in, status_low_byte_in;
   logic [3:0] reg_wr_sel_in, reg_rd_sel_in;
   logic [15:0] reg_wr_data_in, push_data_in;
   logic [2:0] stack_op_in;
   logic [22:0] pc_in;
   wire rd_req_in, rd_byte_in, rd_postinc_in, wr_req_in, wr_byte_in, wr_postinc_in;
   wire [1:0] rd_mode_in, rd_ext_in, wr_mode_in;
   wire [3:0] rd_reg_in, rd_dest_in, wr_reg_in;
   wire [15:0] rd_operand_in, wr_operand_in, wr_data_in, reg_rd_data_out, stack_pointer_reg_out, rd_data_out;
   wire rd_valid_out, addr_error_trap_out, pop_valid_out;
   wire [23:0] rd_ext_addr_out, wr_ext_addr_out;
   wire [22:0] pop_pc_out;
   wire [7:0] pop_status_out;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   dsas_core_model core_u (.clk_in, .rd_req_out(rd_req_in), .rd_byte_out(rd_byte_in), .rd_mode_out(rd_mode_in),
      .rd_operand_out(rd_operand_in), .rd_reg_out(rd_reg_in), .rd_postinc_out(rd_postinc_in), .rd_ext_out(rd_ext_in),
      .rd_dest_out(rd_dest_in), .wr_req_out(wr_req_in), .wr_byte_out(wr_byte_in), .wr_mode_out(wr_mode_in),
      .wr_operand_out(wr_operand_in), .wr_reg_out(wr_reg_in), .wr_postinc_out(wr_postinc_in), .wr_data_out(wr_data_in));
   dsas_access dut_u (.clk_in, .reset_n_in, .enable_in, .rd_req_in, .rd_byte_in, .rd_mode_in, .rd_operand_in,
      .rd_reg_in, .rd_postinc_in, .rd_dest_in, .rd_ext_in, .wr_req_in, .wr_byte_in, .wr_mode_in, .wr_operand_in,
      .wr_reg_in, .wr_postinc_in, .wr_data_in, .read_page_reg_in, .write_page_reg_in, .frame_active_flag_in,
      .reg_wr_in, .reg_wr_sel_in, .reg_wr_data_in, .stack_op_in, .pc_in, .status_low_byte_in, .push_data_in,
      .reg_rd_sel_in, .reg_rd_data_out, .stack_pointer_reg_out, .rd_data_out, .rd_valid_out, .rd_ext_addr_out,
      .wr_ext_addr_out, .addr_error_trap_out, .pop_pc_out, .pop_status_out, .pop_valid_out);
   // 100 ns clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // hang guard
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pulse seen within six cycles: 0 read, 1 trap, 2 pop
   task automatic pulse(input int k);
      bit seen;
      seen = 0;
      repeat (6) begin
         @(posedge clk_in);
         #1;
         if (k == 0 && rd_valid_out === 1'b1 || k == 1 && addr_error_trap_out === 1'b1) seen = 1;
         if (k == 2 && pop_valid_out === 1'b1) seen = 1;
      end
      chk(seen, 1'b1);
   endtask
   task automatic rdw(input logic b, input logic [15:0] a, input logic [15:0] exp);
      core_u.rd(b, 2'h1, a, 4'h0, 1'b0, 2'h0, 4'h0);
      pulse(0);
      chk(rd_data_out, exp);
   endtask
   task automatic wrw(input logic b, input logic [15:0] a, input logic [15:0] w);
      core_u.wr(b, 2'h1, a, 4'h0, 1'b0, w);
      repeat (3) @(posedge clk_in);
   endtask
   task automatic setr(input logic [3:0] r, input logic [15:0] v);
      @(posedge clk_in);
      {reg_wr_in, reg_wr_sel_in, reg_wr_data_in} <= {1'b1, r, v};
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic regchk(input logic [3:0] r, input logic [15:0] exp);
      @(posedge clk_in);
      reg_rd_sel_in <= r;
      repeat (3) @(posedge clk_in);
      #1 chk(reg_rd_data_out, exp);
   endtask
   task automatic sop(input logic [2:0] op, input logic [22:0] pc, input logic [7:0] st);
      @(posedge clk_in);
      {stack_op_in, pc_in, status_low_byte_in} <= {op, pc, st};
      push_data_in <= pc[15:0];
      @(posedge clk_in);
      stack_op_in <= 3'h0;
   endtask
   task automatic t_lanes();
      wrw(0, 16'h1000, 16'h1234);
      rdw(0, 16'h1000, 16'h1234);
      chk(rd_ext_addr_out, 24'h051000);
      rdw(1, 16'h1001, 16'h0012);
      wrw(1, 16'h1001, 16'h00ab);
      chk(wr_ext_addr_out, 24'h071001);
      rdw(0, 16'h1000, 16'hab34);
      rdw(0, 16'hd000, 16'h0000);
      rdw(1, 16'hfff1, 16'h0000);
   endtask
   task automatic t_trap();
      wrw(0, 16'h1002, 16'h5555);
      core_u.wr(0, 2'h1, 16'h1003, 4'h0, 1'b0, 16'hffff);
      pulse(1);
      rdw(0, 16'h1002, 16'h5555);
      core_u.rd(0, 2'h1, 16'h1005, 4'h0, 1'b0, 2'h0, 4'h0);
      pulse(1);
   endtask
   task automatic t_indirect();
      setr(2, 16'h1000);
      core_u.rd(0, 2'h0, 16'h0000, 4'h2, 1'b1, 2'h0, 4'h0);
      pulse(0);
      chk(rd_data_out, 16'hab34);
      regchk(2, 16'h1002);
      core_u.rd(1, 2'h0, 16'h0000, 4'h2, 1'b1, 2'h0, 4'h0);
      pulse(0);
      regchk(2, 16'h1003);
      core_u.rd(0, 2'h2, 16'hf000, 4'h0, 1'b0, 2'h0, 4'h0);
      pulse(0);
      chk(rd_data_out, 16'hab34);
   endtask
   task automatic t_extend();
      setr(3, 16'hff00);
      core_u.rd(1, 2'h1, 16'h1001, 4'h0, 1'b0, 2'h3, 4'h3);
      pulse(0);
      regchk(3, 16'hffab);
      core_u.rd(1, 2'h1, 16'h1001, 4'h0, 1'b0, 2'h3, 4'h4);
      pulse(0);
      core_u.ext(2'h1, 4'h4);
      regchk(4, 16'hffab);
      setr(5, 16'h1200);
      core_u.rd(1, 2'h1, 16'h1001, 4'h0, 1'b0, 2'h3, 4'h5);
      pulse(0);
      core_u.ext(2'h2, 4'h5);
      regchk(5, 16'h00ab);
   endtask
   task automatic t_stack();
      chk(stack_pointer_reg_out, 16'h1000);
      setr(15, 16'h1101);
      regchk(15, 16'h1100);
      sop(3'h1, 23'h5a1234, 8'h00);
      regchk(15, 16'h1104);
      rdw(0, 16'h1100, 16'h1234);
      rdw(0, 16'h1102, 16'h005a);
      sop(3'h2, 23'h7fbeef, 8'hc3);
      repeat (4) @(posedge clk_in);
      rdw(0, 16'h1104, 16'hbeef);
      rdw(0, 16'h1106, 16'hc37f);
      sop(3'h4, 23'h000000, 8'h00);
      pulse(2);
      chk(pop_status_out, 8'hc3);
      chk(pop_pc_out, 23'h7fbeef);
      sop(3'h3, 23'h000000, 8'h00);
      pulse(2);
      chk(pop_pc_out, 23'h5a1234);
      regchk(15, 16'h1100);
      sop(3'h5, 23'h004c1d, 8'h00);
      sop(3'h6, 23'h000000, 8'h00);
      pulse(2);
      chk(pop_pc_out, 23'h004c1d);
      regchk(15, 16'h1100);
      core_u.wr(0, 2'h0, 16'h0000, 4'hf, 1'b0, 16'h0000);
      repeat (3) @(posedge clk_in);
      chk(wr_ext_addr_out, 24'h001100);
      frame_active_flag_in <= 1'b1;
      core_u.wr(0, 2'h0, 16'h0000, 4'he, 1'b0, 16'h0000);
      repeat (3) @(posedge clk_in);
      #1 chk(wr_ext_addr_out, 24'h000000);
   endtask
   // reset, then the scenarios in turn
   initial begin
      {reset_n_in, frame_active_flag_in, reg_wr_in, reg_wr_sel_in, reg_rd_sel_in, stack_op_in} = '0;
      {reg_wr_data_in, push_data_in, pc_in, status_low_byte_in} = '0;
      enable_in = 1'b1;
      read_page_reg_in = 8'h05;
      write_page_reg_in = 8'h07;
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_stack();
      t_lanes();
      t_trap();
      t_indirect();
      t_extend();
      summarize();
   end
endmodule // data_space_access_and_stack_test

// [verification/dsas_checker.sv]
// assertion checker bound to the data-space access block
module dsas_checker (
   input wire clk_in, // core clock
   input wire reset_n_in, // async reset, active low
   input wire rd_req_in, // read request
   input wire rd_byte_in, // byte read
   input wire [1:0] rd_mode_in, // read mode
   input wire [15:0] rd_operand_in, // read address
   input wire wr_req_in, // write request
   input wire wr_byte_in, // byte write
   input wire [1:0] wr_mode_in, // write mode
   input wire [15:0] wr_operand_in, // write address
   input wire [2:0] stack_op_in, // stack command
   input wire [15:0] stack_pointer_reg_out, // stack pointer
   input wire [15:0] rd_data_out, // read result
   input wire rd_valid_out, // read valid pulse
   input wire addr_error_trap_out, // trap pulse
   input wire pop_valid_out // pop valid pulse
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // read answers and zero fill
   chk_read_answer: assert property (rd_valid_out |-> $past(rd_req_in, 2))
      else $error("read answer without a request");
   chk_unimpl_zero: assert property (rd_req_in && rd_mode_in == 2'h1 && rd_operand_in > 16'hcfff
      && (rd_byte_in || !rd_operand_in[0]) |-> ##2 rd_valid_out && rd_data_out == 16'h0000)
      else $error("read above implemented space not zero");
   // misaligned word access
   chk_odd_word_trap: assert property (stack_op_in == 3'h0 && (rd_req_in && !rd_byte_in && rd_mode_in == 2'h1
      && rd_operand_in[0] || wr_req_in && !wr_byte_in && wr_mode_in == 2'h1 && wr_operand_in[0])
      |-> ##2 addr_error_trap_out) else $error("odd word access gave no trap");
   chk_trap_cause: assert property (addr_error_trap_out |->
      $past(rd_req_in && !rd_byte_in || wr_req_in && !wr_byte_in, 2)) else $error("trap without word access");
   // stack pointer
   chk_sp_even: assert property (!stack_pointer_reg_out[0]) else $error("stack pointer odd");
   chk_sp_reset: assert property ($rose(reset_n_in) |-> stack_pointer_reg_out == 16'h1000)
      else $error("stack pointer reset value wrong");
   chk_call_step: assert property (stack_op_in == 3'h1 |->
      ##3 stack_pointer_reg_out == $past(stack_pointer_reg_out, 3) + 16'h0004) else $error("call step wrong");
   chk_pop_answer: assert property (stack_op_in == 3'h6 |-> ##2 pop_valid_out)
      else $error("pop answer late");
   chk_ret_answer: assert property (stack_op_in == 3'h3 |-> ##4 pop_valid_out)
      else $error("return answer late");
endmodule // dsas_checker
bind dsas_access dsas_checker chk_u (.clk_in, .reset_n_in, .rd_req_in, .rd_byte_in, .rd_mode_in, .rd_operand_in,
   .wr_req_in, .wr_byte_in, .wr_mode_in, .wr_operand_in, .stack_op_in, .stack_pointer_reg_out, .rd_data_out,
   .rd_valid_out, .addr_error_trap_out, .pop_valid_out);

// [verification/dsas_core_model.sv]
// core-side model driving the read and write address generation units
module dsas_core_model (
   input wire clk_in, // core clock
   output logic rd_req_out, // read request
   output logic rd_byte_out, // byte read
   output logic [1:0] rd_mode_out, // read mode
   output logic [15:0] rd_operand_out, // read address or field
   output logic [3:0] rd_reg_out, // read pointer register
   output logic rd_postinc_out, // read post-increment
   output logic [1:0] rd_ext_out, // load or extend select
   output logic [3:0] rd_dest_out, // destination register
   output logic wr_req_out, // write request
   output logic wr_byte_out, // byte write
   output logic [1:0] wr_mode_out, // write mode
   output logic [15:0] wr_operand_out, // write address or field
   output logic [3:0] wr_reg_out, // write pointer register
   output logic wr_postinc_out, // write post-increment
   output logic [15:0] wr_data_out // write data
);
   // idle values at time zero
   initial begin
      {rd_req_out, rd_byte_out, rd_mode_out, rd_operand_out, rd_reg_out, rd_postinc_out, rd_ext_out} = '0;
      {rd_dest_out, wr_req_out, wr_byte_out, wr_mode_out, wr_operand_out, wr_reg_out, wr_postinc_out} = '0;
      wr_data_out = 16'h0000;
   end
   // one-cycle read request, address scrambled once released
   task automatic rd(input logic b, input logic [1:0] m, input logic [15:0] a, input logic [3:0] r,
         input logic p, input logic [1:0] x, input logic [3:0] d);
      @(posedge clk_in);
      {rd_req_out, rd_byte_out, rd_mode_out, rd_operand_out, rd_reg_out, rd_postinc_out} <= {1'b1, b, m, a, r, p};
      {rd_ext_out, rd_dest_out} <= {x, d};
      @(posedge clk_in);
      rd_req_out <= 1'b0;
      rd_ext_out <= 2'h0;
      rd_operand_out <= ~a;
   endtask
   // one-cycle register-only extend on a working register
   task automatic ext(input logic [1:0] x, input logic [3:0] d);
      @(posedge clk_in);
      {rd_ext_out, rd_dest_out} <= {x, d};
      @(posedge clk_in);
      rd_ext_out <= 2'h0;
   endtask
   // one-cycle write request on its own unit
   task automatic wr(input logic b, input logic [1:0] m, input logic [15:0] a, input logic [3:0] r,
         input logic p, input logic [15:0] w);
      @(posedge clk_in);
      {wr_req_out, wr_byte_out, wr_mode_out, wr_operand_out, wr_reg_out, wr_postinc_out} <= {1'b1, b, m, a, r, p};
      wr_data_out <= w;
      @(posedge clk_in);
      wr_req_out <= 1'b0;
      wr_operand_out <= ~a;
      wr_data_out <= ~w;
   endtask
endmodule // dsas_core_model
